// File: fam_chk.sv
/* port checker for fam_monitor.
   assumes bind onto every fam_monitor instance. */
`timescale 1ns/100ps
module fam_chk (input wire mclk_in, input wire sys_rst_in,
    input wire [4:0] fan_drive_in, input wire [4:0] fan_fault_out,
    input wire ready_fault_out, input wire [15:0] fault_code_out);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    wire [4:0] f = fan_fault_out;
    property p_edge; $rose(f[0]) || $rose(f[1]) |=> fault_code_out == 16'h6900;
    endproperty
    a_edge: assert property (p_edge) else $error("bad edge code");
    property p_rdy; $rose(ready_fault_out) && f[1:0] == 2'h0 |=>
        fault_code_out == 16'h6910; endproperty
    a_rdy: assert property (p_rdy) else $error("bad ready code");
    property p_front; $rose(f[2]) && f[1:0] == 2'h0 && !ready_fault_out |=>
        fault_code_out == 16'h6920; endproperty
    a_front: assert property (p_front) else $error("bad front code");
    property p_rear; $rose(f[3]) && f[2:0] == 3'h0 && !ready_fault_out |=>
        fault_code_out == 16'h6930; endproperty
    a_rear: assert property (p_rear) else $error("bad rear code");
    property p_ih; $rose(f[4]) && f[3:0] == 4'h0 && !ready_fault_out |=>
        fault_code_out == 16'h6940; endproperty
    a_ih: assert property (p_ih) else $error("bad ih code");
    property p_gate; (f & ~$past(f) & ~($past(fan_drive_in) &
        $past(fan_drive_in, 8))) == 5'h00; endproperty
    a_gate: assert property (p_gate) else $error("fault without drive");
endmodule // fam_chk
bind fam_monitor fam_chk chk_i (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in),
    .fan_drive_in(fan_drive_in), .fan_fault_out(fan_fault_out),
    .ready_fault_out(ready_fault_out), .fault_code_out(fault_code_out));

// File: fam_fans.sv
/* cooling fan model: one alarm pin per fan.
   assumes the bench chooses which fans are stalled. */
`timescale 1ns/100ps
module fam_fans (input wire [4:0] fail_in, output wire [4:0] fan_alarm_out);
    // stalled fan holds alarm even unpowered, so drive gating is exercised
    assign fan_alarm_out = fail_in;
endmodule // fam_fans

// File: fam_map.vh
/*
 fan alarm / warm-up fault monitor constants: fault codes, timing counts.
 assumes a 10 MHz system clock.
*/
`ifndef FAM_MAP_VH
`define FAM_MAP_VH
`define FAM_CLK_HZ 10000000
`define FAM_ALARM_S 5
`define FAM_ALARM_W 26
`define FAM_ALARM_CYC 26'h2FAF080
`define FAM_WARM_MIN 60
`define FAM_WARM_W 36
`define FAM_WARM_CYC 36'h861C46800
`define FAM_CODE_EDGE 16'h6900
`define FAM_CODE_READY 16'h6910
`define FAM_CODE_FRONT 16'h6920
`define FAM_CODE_REAR 16'h6930
`define FAM_CODE_IH 16'h6940
`define FAM_CODE_NONE 16'h0000
`define FAM_NFAN 5
`endif

// File: fam_monitor.v
/*
 fan alarm and warm-up ready fault monitor.
 assumes fan drive levels come from logic on mclk_in; alarm, warm-up and
 ready levels come from pins and are synchronised here.
*/
`timescale 1ns/100ps
`include "fam_map.vh"

// Overview of operation
// - edge fan 1 or 2 driven with alarm held 5 s gives code 6900
// - no ready within 60 minutes of warm-up start gives code 6910
// - front fan driven with alarm held 5 s gives code 6920
// - rear fan driven with alarm held 5 s gives code 6930
// - IH fan driven with alarm held 5 s gives code 6940
module fam_monitor #(
    parameter [`FAM_ALARM_W-1:0] ALARM_CYC = `FAM_ALARM_CYC,
    parameter [`FAM_WARM_W-1:0] WARM_CYC = `FAM_WARM_CYC
) (
    input wire mclk_in,
    input wire sys_rst_in,
    input wire [4:0] fan_drive_in,
    input wire [4:0] fan_alarm_in,
    input wire warmup_in,
    input wire ready_in,
    output reg [4:0] fan_fault_out,
    output reg ready_fault_out,
    output reg fault_valid_out,
    output reg [15:0] fault_code_out
);
    // fan index: 0 edge1, 1 edge2, 2 front, 3 rear, 4 IH

    // warm-up supervision states, one-hot
    localparam [3:0] WS_IDLE = 4'h1;
    localparam [3:0] WS_RUN = 4'h2;
    localparam [3:0] WS_READY = 4'h4;
    localparam [3:0] WS_LATE = 4'h8;

    localparam [`FAM_ALARM_W-1:0] ALM_ZERO = {`FAM_ALARM_W{1'b0}};
    localparam [`FAM_ALARM_W-1:0] ALM_ONE =
        {{(`FAM_ALARM_W-1){1'b0}}, 1'b1};
    localparam [`FAM_ALARM_W-1:0] ALM_LAST = ALARM_CYC - ALM_ONE;
    localparam [`FAM_WARM_W-1:0] WARM_ZERO = {`FAM_WARM_W{1'b0}};
    localparam [`FAM_WARM_W-1:0] WARM_ONE =
        {{(`FAM_WARM_W-1){1'b0}}, 1'b1};

    reg [2:0] warm_s_r;
    reg [2:0] rdy_s_r;
    reg warm_r;
    reg rdy_r;
    reg [3:0] ws_r;
    reg [3:0] ws_nxt;
    reg [`FAM_WARM_W-1:0] warm_cnt_r;
    reg [`FAM_WARM_W-1:0] warm_cnt_nxt;
    reg ready_fault_nxt;
    wire [4:0] fan_fault_nxt;
    reg [15:0] code_nxt;
    reg valid_nxt;

    genvar g;
    generate
        for (g = 0; g < `FAM_NFAN; g = g + 1) begin : g_fan
            reg [2:0] sync_r;
            reg alm_r;
            reg [`FAM_ALARM_W-1:0] cnt_r;
            reg [`FAM_ALARM_W-1:0] cnt_nxt;
            reg flt_nxt;

            // stage one may go metastable; only stages two and three vote
            always @(posedge mclk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    sync_r <= 3'h0;
                    alm_r <= 1'b0;
                end else begin
                    sync_r <= {sync_r[1:0], fan_alarm_in[g]};
                    if (sync_r[1] == sync_r[2]) begin
                        alm_r <= sync_r[2];
                    end
                end
            end

            // drive is from our own clock, so it is used unsynchronised
            always @* begin
                cnt_nxt = cnt_r;
                flt_nxt = fan_fault_out[g];
                if (!(fan_drive_in[g] && alm_r)) begin
                    cnt_nxt = ALM_ZERO;
                end else if (cnt_r < ALARM_CYC) begin
                    cnt_nxt = cnt_r + ALM_ONE;
                end
                // sticky until reset: a fan fault stops the engine
                if (fan_drive_in[g] && alm_r && cnt_r == ALM_LAST) begin
                    flt_nxt = 1'b1;
                end
            end

            // counter saturates, so a long alarm cannot wrap to zero
            always @(posedge mclk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    cnt_r <= ALM_ZERO;
                end else begin
                    cnt_r <= cnt_nxt;
                end
            end

            assign fan_fault_nxt[g] = flt_nxt;
        end
    endgenerate

    // warm-up and ready pins pass the same three-stage filter
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            warm_s_r <= 3'h0;
            rdy_s_r <= 3'h0;
            warm_r <= 1'b0;
            rdy_r <= 1'b0;
        end else begin
            warm_s_r <= {warm_s_r[1:0], warmup_in};
            rdy_s_r <= {rdy_s_r[1:0], ready_in};
            if (warm_s_r[1] == warm_s_r[2]) begin
                warm_r <= warm_s_r[2];
            end
            if (rdy_s_r[1] == rdy_s_r[2]) begin
                rdy_r <= rdy_s_r[2];
            end
        end
    end

    // timer runs from warm-up start until ready is reached or the count hits WARM_CYC
    always @* begin
        ws_nxt = ws_r;
        warm_cnt_nxt = warm_cnt_r;
        ready_fault_nxt = ready_fault_out;
        case (ws_r)
            WS_IDLE: begin
                if (rdy_r) begin
                    ws_nxt = WS_READY;
                end else if (warm_r) begin
                    ws_nxt = WS_RUN;
                    warm_cnt_nxt = WARM_ONE;
                end
            end
            WS_RUN: begin
                if (rdy_r) begin
                    ws_nxt = WS_READY;
                    warm_cnt_nxt = WARM_ZERO;
                end else if (warm_cnt_r == WARM_CYC) begin
                    ws_nxt = WS_LATE;
                    ready_fault_nxt = 1'b1;
                end else begin
                    warm_cnt_nxt = warm_cnt_r + WARM_ONE;
                end
            end
            WS_READY: begin
                // warm-up held after ready restarts only once ready drops
                if (!rdy_r) begin
                    if (warm_r) begin
                        ws_nxt = WS_RUN;
                        warm_cnt_nxt = WARM_ONE;
                    end else begin
                        ws_nxt = WS_IDLE;
                    end
                end
            end
            WS_LATE: begin
                // one report per run; a late ready still ends the run
                if (rdy_r) begin
                    ws_nxt = WS_READY;
                    warm_cnt_nxt = WARM_ZERO;
                end
            end
            default: begin
                ws_nxt = WS_IDLE;
                warm_cnt_nxt = WARM_ZERO;
            end
        endcase
    end

    // lowest code wins when several faults stand together
    always @* begin
        if (fan_fault_out[0] || fan_fault_out[1]) begin
            code_nxt = `FAM_CODE_EDGE;
        end else if (ready_fault_out) begin
            code_nxt = `FAM_CODE_READY;
        end else if (fan_fault_out[2]) begin
            code_nxt = `FAM_CODE_FRONT;
        end else if (fan_fault_out[3]) begin
            code_nxt = `FAM_CODE_REAR;
        end else if (fan_fault_out[4]) begin
            code_nxt = `FAM_CODE_IH;
        end else begin
            code_nxt = `FAM_CODE_NONE;
        end
        valid_nxt = (code_nxt != `FAM_CODE_NONE);
    end

    // code trails the fault flags by one edge; faults never self-clear
    always @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ws_r <= WS_IDLE;
            warm_cnt_r <= WARM_ZERO;
            fan_fault_out <= 5'h00;
            ready_fault_out <= 1'b0;
            fault_code_out <= `FAM_CODE_NONE;
            fault_valid_out <= 1'b0;
        end else begin
            ws_r <= ws_nxt;
            warm_cnt_r <= warm_cnt_nxt;
            fan_fault_out <= fan_fault_nxt;
            ready_fault_out <= ready_fault_nxt;
            fault_code_out <= code_nxt;
            fault_valid_out <= valid_nxt;
        end
    end
endmodule // fam_monitor

// File: tb.sv
/* bench: random fan alarm phases against a hold-time model.
   assumes fam_fans partner and fam_chk bound to the design. */
`timescale 1ns/100ps
module tb;
    reg mclk_in = 0, sys_rst_in = 1, warmup_in = 0, ready_in = 0, rdy;
    reg [4:0] drv = 0, fail = 0, ef = 0;
    wire [4:0] alarm, ff;
    wire rf, fv;
    wire [15:0] code;
    integer mismatches = 0, num_checks = 0, cyc = 0, g, p, len, r;
    always #50 mclk_in = ~mclk_in;
    fam_fans fans (.fail_in(fail), .fan_alarm_out(alarm));
    fam_monitor #(.ALARM_CYC(20), .WARM_CYC(50)) uut (.mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in), .fan_drive_in(drv), .fan_alarm_in(alarm),
        .warmup_in(warmup_in), .ready_in(ready_in), .fan_fault_out(ff),
        .ready_fault_out(rf), .fault_valid_out(fv), .fault_code_out(code));
    function [15:0] ecode(input [4:0] f, input r);
        ecode = |f[1:0] ? 16'h6900 : r ? 16'h6910 : f[2] ? 16'h6920 :
            f[3] ? 16'h6930 : f[4] ? 16'h6940 : 16'h0000;
    endfunction
    task chk(input [15:0] seen, input [15:0] exp); begin
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    end endtask
    task wt(input integer n); begin
        repeat (n) @(posedge mclk_in);
        #10;
    end endtask
    task finish_test; begin
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end endtask
    // ceiling well above the ~800 cycles the groups need at most
    always @(posedge mclk_in) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            finish_test;
        end
    end
    initial begin
        g = $urandom(32'h3e8c7023);
        for (g = 0; g < 5; g = g + 1) begin
            sys_rst_in = 1; ef = 0; warmup_in = 0; ready_in = 0;
            wt(5);
            sys_rst_in = 0; rdy = g[0]; warmup_in = 1; ready_in = rdy;
            wt(2);
            chk({9'h000, ff, rf, fv}, 16'h0000);
            for (p = 0; p < 4; p = p + 1) begin
                // first phase isolates one fan; margins cover sync delay
                r = $urandom;
                drv = p ? r[4:0] : 5'h1F;
                r = $urandom;
                fail = p ? r[4:0] : 5'h01 << g;
                r = $urandom;
                len = (p == 0 || r[0]) ? 30 : 12;
                wt(len);
                if (len == 30) ef = ef | (drv & fail);
                fail = 0;
                wt(8);
                chk(ff, ef);
            end
            chk(rf, !rdy);
            chk(code, ecode(ef, !rdy));
            chk(fv, ecode(ef, !rdy) != 16'h0000);
        end
        finish_test;
    end
endmodule // tb
